// *** hw/slcmd_decoder.sv ***
// slider command decoder top
// Summary of operation
// R1: null code only returns response; burst follows slave select rising.
// R2: code one recalibrates reference with ten bursts; calibrated at power-up (decoder pulses calReq only on code one, never after reset).
// R3: code two finds end points with twenty bursts; disabled at power-up.
// R4: code three bursts and counts drift; one count per ten commands.
// R5: drift command ignored while touch bit is set.
// R6: free-running with select high drifts one step per six bursts.
// R7: top bits 01 load six-bit proximity threshold and burst.
// R8: proximity threshold is ten after reset.
// R9: proximity compare has no hysteresis.
// R10: signal above proximity threshold sets response bit and proximity pin.
// R11: top bits 10 load six-bit touch threshold and burst.
// R12: touch threshold is scaled by four before comparison.
// R13: touch release level is one eighth below scaled threshold.
// R14: touch threshold is ten after reset.
// R15: touch sets response bit seven and touch pin.
// R16: host never loads a zero threshold.
// R17: host keeps select high or pulses it so acquisitions continue.
// R18: host sends calibrations, thresholds, then nulls with periodic drift.
// R19: host recalibrates whenever the error bit is seen.
// R20: host may trigger a burst with a bare select pulse.
// R21: every exchange returns touch plus position, or error and proximity flags.
// R22: every command bursts when select rises after the full byte.
// R23: host waits for ready line after a calibration.
// R24: data change on falling clock edge, sampled on rising edge.
// R25: undefined codes four to sixty-three act as null.
module slcmd_decoder (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       spiClk,
    input  wire logic       ssN,
    input  wire logic       mosi,
    output logic            miso,
    output logic            result_ready_line,
    output logic            proxOut,
    output logic            touchOut,
    output logic            burstReq,
    input  wire logic       burstDone,
    input  wire logic [8:0] signalLevel,
    input  wire logic [6:0] position,
    input  wire logic       polarityErr,
    output logic            calReq,
    output logic            endCalEnable,
    output logic            driftUp,
    output logic            driftDown,
    input  wire logic       driftSign,
    output logic [5:0]      proxThresh,
    output logic [5:0]      touchThresh
);
    logic [7:0] rxByte;
    logic       rxToggle;
    slcmd_pkg::slcmd_resp_t respReg;
    logic       ssSync;
    logic       togSync;
    logic       togSeen;
    logic       ssPrev;
    logic       byteSeen;
    logic [7:0] lastCmd;
    logic [4:0] burstsLeft;
    logic [3:0] driftCount;
    logic [3:0] freeCount;
    logic       touchState;
    logic       proxState;
    logic       isFreeBurst;
    slcmd_pkg::slcmd_state_t state;
    slcmd_pkg::slcmd_state_t next_state;

    // select is read raw by the shifter: the serial clock stands still while it moves
    slcmd_shifter u_shift (
        .spiClk   (spiClk),
        .arst_n   (arst_n),
        .ssHigh   (ssN),
        .mosi     (mosi),
        .respIn   (respReg),
        .miso     (miso),
        .rxByte   (rxByte),
        .rxToggle (rxToggle)
    );

    slcmd_sync u_ssSys (
        .clk    (clk_sys),
        .arst_n (arst_n),
        .din    (ssN),
        .dout   (ssSync)
    );

    slcmd_sync u_togSys (
        .clk    (clk_sys),
        .arst_n (arst_n),
        .din    (rxToggle),
        .dout   (togSync)
    );

    // rxByte is stable long before the toggle lands here
    wire        byteEvent  = togSync ^ togSeen;
    wire        ssRise     = ssSync & ~ssPrev;
    wire        freeRun    = ssSync & ssPrev & (state == slcmd_pkg::SLCMD_IDLE);
    // byte and select edge pass equal synchronisers, so they often land together;
    // decoding the fresh byte directly keeps the burst from using the stale one
    wire [7:0]  cmdNow     = byteEvent ? rxByte : lastCmd;
    wire        seenNow    = byteEvent | byteSeen;
    wire [1:0]  opField    = cmdNow[7:6];
    wire        isCal      = seenNow && (cmdNow == slcmd_pkg::CMD_CAL);
    wire        isEndCal   = seenNow && (cmdNow == slcmd_pkg::CMD_ENDCAL);
    wire        isDrift    = seenNow && (cmdNow == slcmd_pkg::CMD_DRIFT);
    wire        isProxLd   = seenNow && (opField == slcmd_pkg::OP_PROX);
    wire        isTouchLd  = seenNow && (opField == slcmd_pkg::OP_TOUCH);
    wire [4:0]  burstCount = isCal    ? slcmd_pkg::CAL_BURSTS :
                             isEndCal ? slcmd_pkg::ENDCAL_BURSTS : 5'h01;
    wire [8:0]  touchOn    = {1'b0, touchThresh, 2'b00}; // R12
    wire [8:0]  touchOff   = touchOn - (touchOn >> slcmd_pkg::HYST_SH); // R13
    wire        proxHit    = signalLevel > {3'b000, proxThresh}; // R9
    wire        next_touch = touchState ? (signalLevel > touchOff)
                                        : (signalLevel >= touchOn);
    wire        driftTick  = (state == slcmd_pkg::SLCMD_EVAL)
                             && (isFreeBurst || (isDrift && !touchState)); // R5
    wire [3:0]  driftLimit = isFreeBurst ? slcmd_pkg::FREE_RATIO
                                         : slcmd_pkg::DRIFT_CMDS; // R6
    wire [3:0]  driftNow   = isFreeBurst ? freeCount : driftCount;
    wire        driftStep  = driftTick && (driftNow == driftLimit - 4'h1);
    wire [7:0]  next_resp  = touchState ? {1'b1, position}
                                        : {6'h00, polarityErr, proxState}; // R21

    always_comb
    begin
        next_state = state;
        case (state)
            slcmd_pkg::SLCMD_IDLE:
                if (ssRise || freeRun)
                    next_state = slcmd_pkg::SLCMD_REQ; // R22
            slcmd_pkg::SLCMD_REQ:
                next_state = slcmd_pkg::SLCMD_BURST;
            slcmd_pkg::SLCMD_BURST:
                if (burstDone)
                    next_state = slcmd_pkg::SLCMD_EVAL;
            slcmd_pkg::SLCMD_EVAL:
                next_state = (burstsLeft > 5'h01) ? slcmd_pkg::SLCMD_REQ
                                                  : slcmd_pkg::SLCMD_IDLE;
            default:
                next_state = slcmd_pkg::SLCMD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state <= slcmd_pkg::SLCMD_IDLE;
        else
            state <= next_state;
    end

    // command capture; consumed by the burst that select rising starts
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            togSeen  <= 1'b0;
            ssPrev   <= 1'b0;
            byteSeen <= 1'b0;
            lastCmd  <= slcmd_pkg::CMD_NULL;
        end
        else
        begin
            togSeen <= togSync;
            ssPrev  <= ssSync;
            if (byteEvent)
            begin
                byteSeen <= 1'b1;
                lastCmd  <= rxByte;
            end
            else if (state == slcmd_pkg::SLCMD_EVAL && burstsLeft <= 5'h01)
                byteSeen <= 1'b0; // R1 R25
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            burstsLeft  <= 5'h00;
            isFreeBurst <= 1'b0;
        end
        else if (state == slcmd_pkg::SLCMD_IDLE && (ssRise || freeRun))
        begin
            burstsLeft  <= ssRise ? burstCount : 5'h01; // R2 R3
            isFreeBurst <= ~ssRise;
        end
        else if (state == slcmd_pkg::SLCMD_EVAL)
            burstsLeft <= burstsLeft - 5'h01;
    end

    // thresholds and calibration mode, loaded when the burst starts
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            proxThresh   <= slcmd_pkg::PROX_RESET; // R8
            touchThresh  <= slcmd_pkg::TOUCH_RESET; // R14
            endCalEnable <= 1'b0; // R3
            calReq       <= 1'b0;
        end
        else
        begin
            calReq <= 1'b0;
            if (state == slcmd_pkg::SLCMD_IDLE && ssRise)
            begin
                if (isProxLd)
                    proxThresh <= cmdNow[5:0]; // R7
                if (isTouchLd)
                    touchThresh <= cmdNow[5:0]; // R11
                if (isCal)
                begin
                    endCalEnable <= 1'b0; // R2
                    calReq       <= 1'b1;
                end
                if (isEndCal)
                    endCalEnable <= 1'b1; // R3
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            driftCount <= 4'h0;
            freeCount  <= 4'h0;
            driftUp    <= 1'b0;
            driftDown  <= 1'b0;
        end
        else
        begin
            driftUp   <= driftStep & driftSign; // R4
            driftDown <= driftStep & ~driftSign;
            if (driftTick && isFreeBurst)
                freeCount <= driftStep ? 4'h0 : freeCount + 4'h1; // R6
            if (driftTick && !isFreeBurst)
                driftCount <= driftStep ? 4'h0 : driftCount + 4'h1; // R4
        end
    end

    // detection updated at the end of each burst
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            touchState        <= 1'b0;
            proxState         <= 1'b0;
            touchOut          <= 1'b0;
            proxOut           <= 1'b0;
            respReg           <= 8'h00;
            burstReq          <= 1'b0;
            result_ready_line <= 1'b0;
        end
        else
        begin
            burstReq          <= (next_state == slcmd_pkg::SLCMD_REQ);
            result_ready_line <= (next_state == slcmd_pkg::SLCMD_IDLE); // R23
            respReg           <= next_resp;
            if (state == slcmd_pkg::SLCMD_BURST && burstDone)
            begin
                touchState <= next_touch;
                proxState  <= proxHit;
                touchOut   <= next_touch; // R15
                proxOut    <= proxHit; // R10
            end
        end
    end

    // command start checks
    a_cal_burst_cnt: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isCal) |=> burstsLeft == slcmd_pkg::CAL_BURSTS)
        else $error("calibration burst count wrong");
    a_endcal_cnt: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isEndCal)
        |=> burstsLeft == slcmd_pkg::ENDCAL_BURSTS)
        else $error("end calibration burst count wrong");
    a_single_burst: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1 R25
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && !isCal && !isEndCal) |=> burstsLeft == 5'h01)
        else $error("plain command not a single burst");
    a_cal_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isCal) |=> calReq && !endCalEnable)
        else $error("calibration not started");
    a_endcal_on: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isEndCal) |=> endCalEnable)
        else $error("end calibration not enabled");
    a_prox_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isProxLd)
        |=> proxThresh == $past(cmdNow[5:0]))
        else $error("proximity threshold not loaded");
    a_touch_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
        (state == slcmd_pkg::SLCMD_IDLE && ssRise && isTouchLd)
        |=> touchThresh == $past(cmdNow[5:0]))
        else $error("touch threshold not loaded");
    a_burst_start: assert property (@(posedge clk_sys) disable iff (!arst_n) // R22
        (state == slcmd_pkg::SLCMD_IDLE && ssRise) |-> ##[1:2] burstReq)
        else $error("no burst after select rise");
    a_ready_drop: assert property (@(posedge clk_sys) disable iff (!arst_n) // R22 R23
        (state == slcmd_pkg::SLCMD_IDLE && ssRise) |=> !result_ready_line)
        else $error("ready line stays high during burst");
    a_burst_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n) // R22
        burstReq |=> !burstReq)
        else $error("burst request longer than one cycle");

    // detection at burst end
    sequence s_burst_end;
        state == slcmd_pkg::SLCMD_BURST && burstDone;
    endsequence

    a_prox_pin: assert property (@(posedge clk_sys) disable iff (!arst_n) // R9 R10
        s_burst_end
        |=> proxOut == ($past(signalLevel) > {3'b000, $past(proxThresh)}))
        else $error("proximity pin does not follow threshold");
    a_touch_pin: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12 R15
        (s_burst_end ##0 !touchState)
        |=> touchOut == ($past(signalLevel) >= {1'b0, $past(touchThresh), 2'b00}))
        else $error("touch pin does not follow scaled threshold");
    // release written as level plus half the operand, so no subtraction can wrap
    a_touch_release: assert property (@(posedge clk_sys) disable iff (!arst_n) // R13
        (s_burst_end ##0 touchState)
        |=> touchOut == ({1'b0, $past(signalLevel)} + {5'h00, $past(touchThresh[5:1])}
                         > {2'b00, $past(touchThresh), 2'b00}))
        else $error("touch release level wrong");
    a_resp_touch: assert property (@(posedge clk_sys) disable iff (!arst_n) // R21
        touchState |=> respReg.touch && respReg.low == $past(position))
        else $error("touched response lacks position");
    a_resp_idle: assert property (@(posedge clk_sys) disable iff (!arst_n) // R21
        !touchState
        |=> respReg == {6'h00, $past(polarityErr), $past(proxState)})
        else $error("untouched response flags wrong");

    // drift stepping
    a_drift_masked: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
        (state == slcmd_pkg::SLCMD_EVAL && !isFreeBurst && touchState)
        |=> $stable(driftCount))
        else $error("drift counted during touch");
    a_cmd_drift: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
        (state == slcmd_pkg::SLCMD_EVAL && !isFreeBurst && isDrift && !touchState
         && driftCount == slcmd_pkg::DRIFT_CMDS - 4'h1)
        |=> (driftUp || driftDown) && driftCount == 4'h0)
        else $error("drift step missing after tenth command");
    a_free_ratio: assert property (@(posedge clk_sys) disable iff (!arst_n) // R6
        (state == slcmd_pkg::SLCMD_EVAL && isFreeBurst
         && freeCount == slcmd_pkg::FREE_RATIO - 4'h1)
        |=> (driftUp || driftDown) && freeCount == 4'h0)
        else $error("free run drift step missing");
    a_drift_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4 R6
        !driftTick |=> !(driftUp || driftDown))
        else $error("drift step without a drift burst");
endmodule : slcmd_decoder

// *** hw/slcmd_pkg.sv ***
// shared constants and types for the slider command decoder
package slcmd_pkg;
    localparam logic [7:0] CMD_NULL     = 8'h00;
    localparam logic [7:0] CMD_CAL      = 8'h01;
    localparam logic [7:0] CMD_ENDCAL   = 8'h02;
    localparam logic [7:0] CMD_DRIFT    = 8'h03;
    localparam logic [1:0] OP_PROX      = 2'h1;
    localparam logic [1:0] OP_TOUCH     = 2'h2;
    localparam logic [5:0] PROX_RESET   = 6'h0A;
    localparam logic [5:0] TOUCH_RESET  = 6'h0A;
    localparam logic [4:0] CAL_BURSTS   = 5'h0A;
    localparam logic [4:0] ENDCAL_BURSTS = 5'h14;
    localparam logic [3:0] DRIFT_CMDS   = 4'hA;
    localparam logic [3:0] FREE_RATIO   = 4'h6;
    localparam int         TOUCH_SCALE_SH = 2;
    localparam int         HYST_SH      = 3;

    typedef enum logic [2:0] {
        SLCMD_IDLE   = 3'b000,
        SLCMD_REQ    = 3'b001,
        SLCMD_BURST  = 3'b010,
        SLCMD_EVAL   = 3'b011
    } slcmd_state_t;

    // one decoded command handed from the link domain
    typedef struct packed {
        logic [7:0] code;
        logic       hasByte;
    } slcmd_cmd_t;

    // response fields
    typedef struct packed {
        logic       touch;
        logic [6:0] low;
    } slcmd_resp_t;
endpackage : slcmd_pkg

// *** hw/slcmd_sync.sv ***
// two-flop level synchroniser
module slcmd_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : slcmd_sync

// *** hw/slcmd_shifter.sv ***
// spi slave shift engine on the serial clock
module slcmd_shifter (
    input  wire logic       spiClk,
    input  wire logic       arst_n,
    input  wire logic       ssHigh,
    input  wire logic       mosi,
    input  wire logic [7:0] respIn,
    output logic            miso,
    output logic [7:0]      rxByte,
    output logic            rxToggle
);
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [2:0] bitCount;
    wire        lastBit = (bitCount == 3'h7);
    wire [7:0]  nextIn  = {shiftIn[6:0], mosi};

    // sample on rising edge
    always_ff @(posedge spiClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shiftIn  <= 8'h00;
            bitCount <= 3'h0;
            rxByte   <= 8'h00;
            rxToggle <= 1'b0;
        end
        else if (!ssHigh)
        begin
            shiftIn  <= nextIn; // R24
            bitCount <= bitCount + 3'h1;
            if (lastBit)
            begin
                rxByte   <= nextIn;
                rxToggle <= ~rxToggle;
            end
        end
    end

    // drive on falling edge; response loaded at byte start
    always_ff @(negedge spiClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shiftOut <= 8'h00;
            miso     <= 1'b0;
        end
        else if (!ssHigh)
        begin
            if (bitCount == 3'h0)
            begin
                miso     <= respIn[7]; // R24
                shiftOut <= {respIn[6:0], 1'b0};
            end
            else
            begin
                miso     <= shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
            end
        end
    end
endmodule : slcmd_shifter

// *** verification/slcmd_host.sv ***
// host side spi master model for the slider command decoder
module slcmd_host (
    output logic      spiClk,
    output logic      ssN,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        spiClk = 1'b1;
        ssN    = 1'b0;
        mosi   = 1'b0;
    end
    // whole bytes only: the slave bit counter is cleared only by reset
    task automatic frame(input logic [7:0] cmdByte, output logic [7:0] resp);
        while (ready !== 1'b1) #100;
        for (int i = 7; i >= 0; i--)
        begin
            #6 spiClk = 1'b0;
            mosi = cmdByte[i];
            #6 spiClk = 1'b1;
            resp[i] = miso;
        end
        #20 ssN = 1'b1;
        mosi = ~mosi;
        // short select pulse keeps free-run out of the way
        #400 ssN = 1'b0;
    endtask : frame
    task automatic free_run(input logic on);
        ssN = on;
    endtask : free_run
endmodule : slcmd_host

// *** verification/testbench.sv ***
// self-checking bench for the slider command decoder
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0] proxT;
        logic [5:0] touchT;
        logic       endCal;
        logic       prox;
        logic       touch;
        logic [4:0] bursts;
        logic       cal;
    } slcmd_exp_t;
    logic       clk_sys   = 1'b0;
    logic       arst_n    = 1'b0;
    logic       burstDone = 1'b0;
    logic [8:0] sigLvl    = 9'h000;
    logic [6:0] posIn     = 7'h00;
    logic       errIn     = 1'b0;
    logic       sign      = 1'b0;
    wire        spiClk, ssN, mosi, miso, ready, proxOut, touchOut;
    wire        burstReq, calReq, endCal, dUp, dDown;
    wire  [5:0] proxThresh, touchThresh;
    logic [5:0] mP = slcmd_pkg::PROX_RESET;
    logic [5:0] mTh = slcmd_pkg::TOUCH_RESET;
    logic [6:0] mPos = 7'h00;
    logic       mErr = 1'b0, mEnd = 1'b0, mTouch = 1'b0, mProx = 1'b0;
    logic [7:0] rnd = 8'h5C, r, code;
    logic [5:0] opnd;
    logic       ssPrev = 1'b0, rdyPrev = 1'b0, armed = 1'b0;
    int         err_total = 0, comparisons = 0, cyc = 0, pend = 0, done = 0;
    int         bCnt = 0, calCnt = 0, totB = 0, upCnt = 0, downCnt = 0, u0, d0, b0, n;
    slcmd_exp_t q[$];
    slcmd_exp_t e;
    logic [8:0] lvls[7] = '{9'h00A, 9'h00B, 9'h00A, 9'h027, 9'h028, 9'h024, 9'h023};

    slcmd_decoder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .spiClk(spiClk), .ssN(ssN),
        .mosi(mosi), .miso(miso), .result_ready_line(ready), .proxOut(proxOut),
        .touchOut(touchOut), .burstReq(burstReq), .burstDone(burstDone),
        .signalLevel(sigLvl), .position(posIn), .polarityErr(errIn), .calReq(calReq),
        .endCalEnable(endCal), .driftUp(dUp), .driftDown(dDown), .driftSign(sign),
        .proxThresh(proxThresh), .touchThresh(touchThresh));
    slcmd_host host_u (.spiClk(spiClk), .ssN(ssN), .mosi(mosi), .miso(miso), .ready(ready));

    always #50 clk_sys = ~clk_sys;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // one command frame; expectation noted before the frame is sent
    task automatic cmd(input logic [7:0] c, input logic [8:0] s);
        logic [7:0] resp, expResp, on;
        slcmd_exp_t x;
        int d;
        @(posedge clk_sys);
        #5;
        sigLvl = s;
        posIn = rnd[6:0];
        errIn = rnd[7];
        rnd = lfsr_next(rnd);
        expResp = mTouch ? {1'b1, mPos} : {6'h00, mErr, mProx};
        if (c[7:6] == slcmd_pkg::OP_PROX) mP = c[5:0];
        if (c[7:6] == slcmd_pkg::OP_TOUCH) mTh = c[5:0];
        if (c == slcmd_pkg::CMD_CAL) mEnd = 1'b0;
        if (c == slcmd_pkg::CMD_ENDCAL) mEnd = 1'b1;
        on = {mTh, 2'b00};
        mTouch = mTouch ? (s > on - (on >> 3)) : (s >= on);
        mProx = s > mP;
        x = '{mP, mTh, mEnd, mProx, mTouch, 5'h01, c == slcmd_pkg::CMD_CAL};
        if (c == slcmd_pkg::CMD_CAL) x.bursts = slcmd_pkg::CAL_BURSTS;
        if (c == slcmd_pkg::CMD_ENDCAL) x.bursts = slcmd_pkg::ENDCAL_BURSTS;
        q.push_back(x);
        d = done;
        host_u.frame(c, resp);
        check("response", resp, expResp);
        mPos = posIn;
        mErr = errIn;
        for (int k = 0; k < 600 && done == d; k++) @(posedge clk_sys);
        check("completion", done - d, 1);
    endtask : cmd

    // acquisition engine stand-in: ends each burst three cycles on
    always @(posedge clk_sys)
    begin
        if (burstReq === 1'b1) pend = 3;
        else if (pend != 0) pend = pend - 1;
        #5 burstDone = (pend == 1);
    end

    always @(posedge clk_sys)
    begin
        if (ssN === 1'b1 && ssPrev === 1'b0)
        begin
            bCnt = 0;
            calCnt = 0;
        end
        if (burstReq === 1'b1) bCnt++;
        if (burstReq === 1'b1) totB++;
        if (calReq === 1'b1) calCnt++;
        if (dUp === 1'b1) upCnt++;
        if (dDown === 1'b1) downCnt++;
        if (armed && ready === 1'b1 && rdyPrev === 1'b0 && q.size() != 0)
        begin
            e = q.pop_front();
            check("proxThresh", proxThresh, e.proxT);
            check("touchThresh", touchThresh, e.touchT);
            check("endCalEnable", endCal, e.endCal);
            check("proxOut", proxOut, e.prox);
            check("touchOut", touchOut, e.touch);
            check("bursts", bCnt, e.bursts);
            check("calReq", calCnt, e.cal);
            done++;
        end
        ssPrev = ssN;
        rdyPrev = ready;
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        #5 arst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        armed = 1'b1;
        check("proxThresh", proxThresh, 10);
        check("touchThresh", touchThresh, 10);
        check("endCalEnable", endCal, 0);
        cmd(slcmd_pkg::CMD_NULL, 9'h000);
        foreach (lvls[i]) cmd(slcmd_pkg::CMD_NULL, lvls[i]);
        for (int k = 0; k < 16; k++)
        begin
            r = rnd;
            rnd = lfsr_next(rnd);
            opnd = (rnd[5:0] == 6'h00) ? 6'h01 : rnd[5:0];
            code = (r[1:0] == 2'h0) ? {slcmd_pkg::OP_PROX, opnd} :
                   (r[1:0] == 2'h1) ? {slcmd_pkg::OP_TOUCH, opnd} :
                   (r[1:0] == 2'h2) ? slcmd_pkg::CMD_NULL : 8'h04 + (r % 8'h3C);
            cmd(code, {r[7], rnd});
        end
        cmd(slcmd_pkg::CMD_ENDCAL, 9'h000);
        cmd(slcmd_pkg::CMD_CAL, 9'h000);
        cmd(slcmd_pkg::CMD_ENDCAL, 9'h000);
        @(posedge clk_sys);
        #5 sign = 1'b1;
        u0 = upCnt;
        repeat (10) cmd(slcmd_pkg::CMD_DRIFT, 9'h000);
        check("driftUp", upCnt - u0, 1);
        cmd(slcmd_pkg::CMD_NULL, 9'h1FF);
        u0 = upCnt;
        repeat (10) cmd(slcmd_pkg::CMD_DRIFT, 9'h1FF);
        check("driftUp", upCnt - u0, 0);
        cmd(slcmd_pkg::CMD_NULL, 9'h000);
        @(posedge clk_sys);
        #5 sign = 1'b0;
        d0 = downCnt;
        u0 = upCnt;
        b0 = totB;
        host_u.free_run(1'b1);
        for (n = 0; n < 3000 && totB < b0 + 13; n++) @(posedge clk_sys);
        #5 host_u.free_run(1'b0);
        repeat (20) @(posedge clk_sys);
        check("freeDrift", downCnt - d0, 2);
        check("freeUp", upCnt - u0, 0);
        test_done();
    end
endmodule : testbench
